// File: bench/fpb_fw_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpb_fw_model #(
  parameter int DELAY = 3
)
(
  input wire logic i_clock,
  input wire logic i_cal_load,
  output logic o_cal_done
);
  int cnt = 0;
  // Firmware takes a few cycles of the load phase before it reports done
  always @(posedge i_clock)
    cnt <= (i_cal_load === 1'b1) ? cnt + 1 : 0;
  assign o_cal_done = (i_cal_load === 1'b1) && (cnt >= DELAY);
endmodule
`default_nettype wire

// File: bench/test_fpb_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_fpb_top
  import fpb_pkg::*;
;
  logic clk = 0, srst = 1, pwr = 1, sel_n = 0, wr = 0, rd = 0, req = 0;
  logic [31:0] bword = 32'hFFFFFFFF, wdata = 32'h0;
  logic [7:0] addr = 8'h00;
  logic [15:0] raddr = 16'h0000;
  fpb_op_t op = FPB_OP_NONE;
  fpb_src_t src = FPB_SRC_CORE;
  logic [31:0] rdata;
  logic grant, abort, cal_load, cal_done, user_run, dl_mode;
  int err_count = 0, n_tests = 0;
  fpb_top dut_u (.I_CLOCK(clk), .I_SRST(srst), .I_POWER_ON(pwr), .I_BOOT_SELECT_N(sel_n),
    .I_BOOT_WORD(bword), .I_CAL_DONE(cal_done), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .I_REQ(req), .I_REQ_OP(op), .I_REQ_SRC(src), .I_REQ_ADDR(raddr),
    .O_RDATA(rdata), .O_GRANT(grant), .O_ABORT(abort), .O_CAL_LOAD(cal_load),
    .O_USER_RUN(user_run), .O_DOWNLOAD_MODE(dl_mode));
  fpb_fw_model #(.DELAY(3)) fw_u (.i_clock(clk), .i_cal_load(cal_load), .o_cal_done(cal_done));
  initial
  begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    // Core writes reach only this block's words, so the debug port pins stay put
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
    // Read data stand for one cycle only, then fall back to zero
    @(posedge clk);
    #1;
    chk("rdata_idle", rdata, 32'h0);
  endtask
  // Grant and abort stand only in the cycle after the request edge, so sample right there
  task automatic access(input fpb_op_t o, input fpb_src_t s, input logic [15:0] a,
    input logic ok);
    @(posedge clk);
    op <= o;
    src <= s;
    raddr <= a;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk("grant", {31'h0, grant}, {31'h0, ok});
    chk("abort", {31'h0, abort}, {31'h0, !ok});
  endtask
  task automatic boot(input logic po, input logic pin_n, input logic [31:0] w);
    int i;
    @(posedge clk);
    sel_n <= pin_n;
    bword <= w;
    srst <= 1'b1;
    pwr <= po;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    pwr <= 1'b0;
    for (i = 0; i < 10 && cal_load !== 1'b1; i++)
      @(posedge clk);
    #1;
    chk("cal_load", {31'h0, cal_load}, 32'h1);
    chk("early_run", {30'h0, user_run, dl_mode}, 32'h0);
    for (i = 0; i < 20 && user_run !== 1'b1 && dl_mode !== 1'b1; i++)
      @(posedge clk);
    #1;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk);
    err_count++;
    finish_test;
  end
  initial
  begin
    boot(1'b1, 1'b0, 32'hFFFFFFFF);
    chk("mode", {30'h0, user_run, dl_mode}, 32'h1);
    reg_rd(8'h00, 32'hFFFFFFFF);
    reg_rd(8'h18, 32'h0);
    access(FPB_OP_PROG, FPB_SRC_CORE, 16'h0000, 1'b0);
    access(FPB_OP_ERASE, FPB_SRC_CORE, 16'h0000, 1'b1);
    access(FPB_OP_PROG, FPB_SRC_I2C, 16'h0004, 1'b1);
    access(FPB_OP_PROG, FPB_SRC_CORE, 16'hF800, 1'b0);
    access(FPB_OP_ERASE, FPB_SRC_FW, 16'hF800, 1'b1);
    access(FPB_OP_ERASE, FPB_SRC_I2C, 16'hF7FE, 1'b1);
    reg_wr(8'h00, 32'hFFFFFFFD);
    access(FPB_OP_ERASE, FPB_SRC_I2C, 16'h0800, 1'b0);
    access(FPB_OP_ERASE, FPB_SRC_JTAG, 16'h0FFF, 1'b0);
    access(FPB_OP_ERASE, FPB_SRC_CORE, 16'h1000, 1'b1);
    access(FPB_OP_ERASE, FPB_SRC_CORE, 16'h07FF, 1'b1);
    reg_wr(8'h00, 32'h7FFFFFFF);
    access(FPB_OP_READ, FPB_SRC_JTAG, 16'h0000, 1'b0);
    access(FPB_OP_READ, FPB_SRC_CORE, 16'h0000, 1'b1);
    access(FPB_OP_NONE, FPB_SRC_CORE, 16'h0000, 1'b0);
    reg_wr(8'h04, 32'hFFFFFFFE);
    reg_rd(8'h04, 32'hFFFFFFFE);
    reg_wr(8'h08, 32'h00001234);
    reg_wr(8'h0C, 32'h0000000C);
    reg_rd(8'h14, 32'h7FFFFFFF);
    boot(1'b0, 1'b1, 32'hFFFFFFFF);
    chk("mode", {30'h0, user_run, dl_mode}, 32'h2);
    reg_rd(8'h00, 32'hFFFFFFFF);
    reg_rd(8'h14, 32'hFFFFFFFE);
    access(FPB_OP_ERASE, FPB_SRC_CORE, 16'h0200, 1'b0);
    access(FPB_OP_ERASE, FPB_SRC_I2C, 16'h1000, 1'b0);
    boot(1'b1, 1'b0, 32'h00000000);
    chk("mode", {30'h0, user_run, dl_mode}, 32'h2);
    access(FPB_OP_PROG, FPB_SRC_CORE, 16'h0000, 1'b0);
    reg_wr(8'h08, 32'hDEADDEAD);
    reg_wr(8'h0C, 32'h0000000C);
    reg_rd(8'h10, 32'h00000035);
    reg_wr(8'h08, 32'hDEADDEAD);
    reg_wr(8'h0C, 32'h0000000C);
    reg_rd(8'h10, 32'h00000039);
    finish_test;
  end
endmodule
`default_nettype wire

// File: hw/fpb_page_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpb_params.svh"
module fpb_page_check
  import fpb_pkg::*;
(
  input wire logic [31:0] i_prot,
  input wire logic [15:0] i_addr,
  input wire fpb_pkg::fpb_op_t i_op,
  input wire fpb_pkg::fpb_src_t i_src,
  output logic o_hidden,
  output logic o_write_guard,
  output logic o_read_guard
);
  import fpb_pkg::*;

  function automatic logic [4:0] group_of(input logic [15:0] addr);
    group_of = addr[15:`FPB_GROUP_BITS];
  endfunction

  wire logic is_write;
  wire logic [4:0] grp;

  assign is_write = (i_op == FPB_OP_PROG) || (i_op == FPB_OP_ERASE);
  assign grp = group_of(i_addr);
  // Firmware is the only source allowed into the top 2 kB
  assign o_hidden = (i_addr >= `FPB_USER_LIMIT) && (i_src != FPB_SRC_FW); // R1
  // Cleared bit protects its four pages, whatever the source
  assign o_write_guard = is_write && (i_addr < `FPB_USER_LIMIT) && !i_prot[grp]; // R8 R9 R13
  assign o_read_guard = (i_op == FPB_OP_READ) && (i_src == FPB_SRC_JTAG)
    && !i_prot[`FPB_READ_GUARD_BIT]; // R7
endmodule
`default_nettype wire

// File: hw/fpb_params.svh
// How it works
// R1: 64 kB: 62 kB user, 2 kB hidden
// R2: erase whole pages; program only erased pages
// R3: firmware loads calibration before user code
// R4: download only if pin low and word erased
// R5: I2C host programs user space in download
// R6: user code keeps debug port pins unchanged
// R7: bit 31 blocks JTAG reads of user space
// R8: other 31 bits each guard 2 kB
// R9: guard blocks program and erase, every path
// R10: volatile word acts at once, resets unprotected
// R11: saved word acts after save command and reset
// R12: key 0xDEADDEAD locks saved word for good; this model clears the lock at power-on
// R13: bit n guards pages 4n..4n+3, clear protects
// R14: blocked accesses abort, memory left untouched
`ifndef FPB_PARAMS_SVH
`define FPB_PARAMS_SVH
`define FPB_OFF_VOLATILE 8'h00
`define FPB_OFF_SAVED 8'h04
`define FPB_OFF_KEY 8'h08
`define FPB_OFF_COMMAND 8'h0C
`define FPB_OFF_STATUS 8'h10
`define FPB_OFF_ACTIVE 8'h14
`define FPB_PROT_RESET 32'hFFFFFFFF
`define FPB_KEY_PERMANENT 32'hDEADDEAD
`define FPB_CMD_SAVE 8'h0C
`define FPB_BOOT_WORD_ADDR 20'h80014
`define FPB_BOOT_ERASED 32'hFFFFFFFF
`define FPB_USER_LIMIT 16'hF800
`define FPB_PAGE_BITS 9
`define FPB_GROUP_BITS 11
`define FPB_READ_GUARD_BIT 31
`define FPB_PAGES 128
`define FPB_BOOT_WAIT 2'h2
`endif

// File: hw/fpb_pkg.sv
package fpb_pkg;
  typedef enum logic [1:0] {FPB_OP_READ, FPB_OP_PROG, FPB_OP_ERASE, FPB_OP_NONE} fpb_op_t;
  typedef enum logic [1:0] {FPB_SRC_CORE, FPB_SRC_I2C, FPB_SRC_JTAG, FPB_SRC_FW} fpb_src_t;
  typedef enum logic [1:0] {FPB_ST_STRAP, FPB_ST_CONFIG, FPB_ST_USER, FPB_ST_DOWNLOAD} fpb_state_t;
endpackage

// File: hw/fpb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpb_params.svh"
module fpb_top
  import fpb_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic I_POWER_ON,
  input wire logic I_BOOT_SELECT_N,
  input wire logic [31:0] I_BOOT_WORD,
  input wire logic I_CAL_DONE,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_REQ,
  input wire fpb_pkg::fpb_op_t I_REQ_OP,
  input wire fpb_pkg::fpb_src_t I_REQ_SRC,
  input wire logic [15:0] I_REQ_ADDR,
  output logic [31:0] O_RDATA,
  output logic O_GRANT,
  output logic O_ABORT,
  output logic O_CAL_LOAD,
  output logic O_USER_RUN,
  output logic O_DOWNLOAD_MODE
);
  import fpb_pkg::*;

  fpb_state_t state;
  fpb_state_t next_state;
  logic [31:0] volatile_protection_word;
  logic [31:0] saved_protection_word;
  logic [31:0] key_entry;
  logic [31:0] nv_saved;
  logic [31:0] nv_key;
  logic nv_key_set;
  logic nv_permanent;
  logic [31:0] active_saved;
  logic cmd_pass;
  logic cmd_fail;
  logic [1:0] boot_wait;
  logic boot_sync1;
  logic boot_sync2;
  logic [`FPB_PAGES-1:0] page_erased;

  wire logic [31:0] eff_prot;
  wire logic hidden;
  wire logic write_guard;
  wire logic read_guard;
  wire logic [6:0] req_page;
  wire logic mode_block;
  wire logic erase_block;
  wire logic refuse;
  wire logic wr_save;
  wire logic save_ok;
  wire logic want_download;
  wire logic [31:0] status_word;
  wire logic [31:0] next_rdata;

  // Either word can protect; a cleared bit in one is enough
  assign eff_prot = volatile_protection_word & active_saved; // R9

  fpb_page_check u_check (
    .i_prot(eff_prot),
    .i_addr(I_REQ_ADDR),
    .i_op(I_REQ_OP),
    .i_src(I_REQ_SRC),
    .o_hidden(hidden),
    .o_write_guard(write_guard),
    .o_read_guard(read_guard)
  );

  assign req_page = I_REQ_ADDR[15:`FPB_PAGE_BITS];
  // The I2C host only reaches the array while download mode is up
  assign mode_block = (I_REQ_SRC == FPB_SRC_I2C) && !O_DOWNLOAD_MODE; // R5
  assign erase_block = (I_REQ_OP == FPB_OP_PROG) && !page_erased[req_page]; // R2
  assign refuse = hidden || write_guard || read_guard || mode_block || erase_block
    || (I_REQ_OP == FPB_OP_NONE); // R14

  assign wr_save = I_WR && (I_ADDR == `FPB_OFF_COMMAND) && (I_WDATA[7:0] == `FPB_CMD_SAVE);
  // First save sets the key; later saves need the same key and no lock
  assign save_ok = !nv_key_set || (!nv_permanent && (key_entry == nv_key)); // R12

  assign want_download = !boot_sync2 && (I_BOOT_WORD == `FPB_BOOT_ERASED); // R4

  assign status_word = {26'h0, nv_permanent, nv_key_set, cmd_fail, cmd_pass,
    O_DOWNLOAD_MODE, O_USER_RUN};
  // Key reads back as zero so software cannot learn it
  assign next_rdata = !I_RD ? 32'h00000000 :
    (I_ADDR == `FPB_OFF_VOLATILE) ? volatile_protection_word :
    (I_ADDR == `FPB_OFF_SAVED) ? saved_protection_word :
    (I_ADDR == `FPB_OFF_STATUS) ? status_word :
    (I_ADDR == `FPB_OFF_ACTIVE) ? eff_prot : 32'h00000000;

  always_comb
  begin
    next_state = state;
    unique case (state)
      FPB_ST_STRAP:
        if (boot_wait == `FPB_BOOT_WAIT)
          next_state = FPB_ST_CONFIG;
      FPB_ST_CONFIG:
        if (I_CAL_DONE)
          next_state = want_download ? FPB_ST_DOWNLOAD : FPB_ST_USER; // R3 R4
      FPB_ST_USER:
        next_state = FPB_ST_USER;
      FPB_ST_DOWNLOAD:
        next_state = FPB_ST_DOWNLOAD;
    endcase
  end

  // Pin synchroniser left out of reset: it only carries data
  always_ff @(posedge I_CLOCK)
  begin
    boot_sync1 <= I_BOOT_SELECT_N;
    boot_sync2 <= boot_sync1;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST || I_POWER_ON)
    begin
      state <= FPB_ST_STRAP;
      boot_wait <= 2'h0;
      O_CAL_LOAD <= 1'b0;
      O_USER_RUN <= 1'b0;
      O_DOWNLOAD_MODE <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // Lets the pin settle through the synchroniser after release
      if (boot_wait != `FPB_BOOT_WAIT)
        boot_wait <= boot_wait + 2'h1;
      O_CAL_LOAD <= (next_state == FPB_ST_CONFIG); // R3
      O_USER_RUN <= (next_state == FPB_ST_USER);
      O_DOWNLOAD_MODE <= (next_state == FPB_ST_DOWNLOAD);
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST || I_POWER_ON)
    begin
      volatile_protection_word <= `FPB_PROT_RESET; // R10
      saved_protection_word <= `FPB_PROT_RESET;
      key_entry <= 32'h00000000;
      cmd_pass <= 1'b0;
      cmd_fail <= 1'b0;
      O_RDATA <= 32'h00000000;
    end
    else
    begin
      if (I_WR && (I_ADDR == `FPB_OFF_VOLATILE))
        volatile_protection_word <= I_WDATA; // R10
      if (I_WR && (I_ADDR == `FPB_OFF_SAVED))
        saved_protection_word <= I_WDATA;
      if (I_WR && (I_ADDR == `FPB_OFF_KEY))
        key_entry <= I_WDATA;
      // Status flags clear on read unless a new save result lands
      if (wr_save)
      begin
        cmd_pass <= save_ok;
        cmd_fail <= !save_ok; // R12
      end
      else if (I_RD && (I_ADDR == `FPB_OFF_STATUS))
      begin
        cmd_pass <= 1'b0;
        cmd_fail <= 1'b0;
      end
      O_RDATA <= next_rdata;
    end
  end

  // Saved word only reaches the guard logic at a reset
  always_ff @(posedge I_CLOCK)
  begin
    if (I_POWER_ON)
      active_saved <= `FPB_PROT_RESET;
    else if (I_SRST)
      active_saved <= nv_saved; // R11
  end

  // Stands in for the nonvolatile cells: only power-on clears them
  always_ff @(posedge I_CLOCK)
  begin
    if (I_POWER_ON)
    begin
      nv_saved <= `FPB_PROT_RESET;
      nv_key <= 32'h00000000;
      nv_key_set <= 1'b0;
      nv_permanent <= 1'b0;
      page_erased <= '0;
    end
    else
    begin
      if (wr_save && save_ok && !I_SRST)
      begin
        nv_saved <= saved_protection_word; // R11
        nv_key <= key_entry;
        nv_key_set <= 1'b1;
        nv_permanent <= (key_entry == `FPB_KEY_PERMANENT); // R12
      end
      if (I_REQ && !refuse && (I_REQ_OP == FPB_OP_ERASE))
        page_erased[req_page] <= 1'b1; // R2
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST || I_POWER_ON)
    begin
      O_GRANT <= 1'b0;
      O_ABORT <= 1'b0;
    end
    else
    begin
      O_GRANT <= I_REQ && !refuse;
      O_ABORT <= I_REQ && refuse; // R14
    end
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST || I_POWER_ON);

  sequence cfg_done_s;
    (state == FPB_ST_CONFIG) && I_CAL_DONE;
  endsequence
  sequence run_up_s;
    ##1 ((O_USER_RUN ^ O_DOWNLOAD_MODE) && !O_CAL_LOAD);
  endsequence

  hidden_abort_a: assert property (I_REQ && (I_REQ_ADDR >= `FPB_USER_LIMIT) // R1
    && (I_REQ_SRC != FPB_SRC_FW) |=> O_ABORT && !O_GRANT)
    else $error("hidden area access not aborted");
  prog_unerased_a: assert property (I_REQ && (I_REQ_OP == FPB_OP_PROG) // R2
    && !page_erased[req_page] |=> O_ABORT)
    else $error("program of unerased page granted");
  cal_before_user_a: assert property (cfg_done_s |-> run_up_s) // R3
    else $error("boot did not follow calibration");
  user_needs_cal_a: assert property ($rose(O_USER_RUN) |-> $past(O_CAL_LOAD)) // R3
    else $error("user code started without calibration");
  boot_choice_a: assert property (cfg_done_s and (want_download) |=> O_DOWNLOAD_MODE) // R4
    else $error("download strap ignored");
  i2c_mode_a: assert property (I_REQ && (I_REQ_SRC == FPB_SRC_I2C) // R5
    && !O_DOWNLOAD_MODE |=> O_ABORT)
    else $error("I2C access outside download mode");
  jtag_read_a: assert property (I_REQ && (I_REQ_OP == FPB_OP_READ) // R7
    && (I_REQ_SRC == FPB_SRC_JTAG) && !eff_prot[31] |=> O_ABORT)
    else $error("JTAG read not blocked");
  write_guard_a: assert property (I_REQ && (I_REQ_OP != FPB_OP_READ) // R9
    && (I_REQ_ADDR < `FPB_USER_LIMIT) && !eff_prot[I_REQ_ADDR[15:11]] |=> !O_GRANT)
    else $error("protected group written");
  vol_effect_a: assert property (I_WR && (I_ADDR == `FPB_OFF_VOLATILE) // R10
    |=> volatile_protection_word == $past(I_WDATA))
    else $error("volatile word not applied");
  saved_hold_a: assert property (@(posedge I_CLOCK) disable iff (I_POWER_ON) // R11
    !I_SRST |=> $stable(active_saved))
    else $error("saved word applied without reset");
  perm_lock_a: assert property (wr_save && nv_permanent && !I_SRST // R12
    |=> $stable(nv_saved) && cmd_fail)
    else $error("permanent lock overwritten");
endmodule
`default_nettype wire
